// ==== shared/gcfs_pkg.sv ====
// Package for the group-send and communication fault supervisor
package gcfs_pkg;

	// ------------------------------------------------------------
	// Register map and field values
	// ------------------------------------------------------------
	localparam logic [15:0] gcfs_group_addr_offset = 16'h0031;
	localparam logic [15:0] gcfs_group_none = 16'hffff;   // -1, no group
	localparam logic [15:0] gcfs_group_reset = 16'hffff;
	localparam logic [7:0] gcfs_group_min = 8'h01;
	localparam logic [7:0] gcfs_group_max = 8'h1f;

	// ------------------------------------------------------------
	// Communication error record codes
	// ------------------------------------------------------------
	localparam logic [7:0] gcfs_err_xmit = 8'h12;
	localparam logic [7:0] gcfs_err_timeout = 8'h13;
	localparam logic [7:0] gcfs_err_undef = 8'he0;
	localparam logic [7:0] gcfs_err_range = 8'he1;
	localparam logic [7:0] gcfs_err_disable = 8'he2;
	localparam logic [7:0] gcfs_err_nvbusy = 8'he3;

	// Exception codes
	localparam logic [7:0] gcfs_exc_func = 8'h01;
	localparam logic [7:0] gcfs_exc_addr = 8'h02;
	localparam logic [7:0] gcfs_exc_value = 8'h03;
	localparam logic [7:0] gcfs_exc_fail = 8'h04;

	// Warning and alarm codes
	localparam logic [7:0] gcfs_wrn_comm = 8'h20;
	localparam logic [7:0] gcfs_alm_comm = 8'h12;
	localparam logic [7:0] gcfs_alm_timeout = 8'h13;
	localparam logic [7:0] gcfs_alm_none = 8'h00;

	// ------------------------------------------------------------
	// Sizes and timing
	// ------------------------------------------------------------
	localparam int gcfs_hist_depth = 10;
	localparam int gcfs_rec_depth = 8;
	localparam int gcfs_clk_hz = 25000000;
	localparam int gcfs_ms_cycles = gcfs_clk_hz / 1000;
	localparam int gcfs_clear_hold_ms = 10;
	localparam int gcfs_clear_hold_cycles = gcfs_clear_hold_ms * gcfs_ms_cycles;
	localparam int gcfs_blink_on_ms = 200;
	localparam int gcfs_blink_gap_ms = 1500;
	localparam logic [15:0] gcfs_timeout_reset_ms = 16'h0000;
	localparam logic [3:0] gcfs_err_limit_reset = 4'h3;

	// Frame event from the protocol engine
	typedef struct packed {
		logic done;        // frame finished, one-cycle pulse
		logic crc_error;   // transmission error seen
		logic [7:0] station; // addressed station
		logic exception;   // answer carries an exception
		logic [7:0] exc_code;
		logic exc_nvbusy;  // code 04h caused by nonvolatile busy
	} gcfs_frame_t;

	// Register access from the protocol engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} gcfs_reg_t;

endpackage : gcfs_pkg

// ==== sim/gcfs_master_model.sv ====
// Behavioural bus master issuing frame events and register accesses
module gcfs_master_model
	import gcfs_pkg::*;
(
	input wire logic clk,              // Bench clock
	output gcfs_frame_t frame,         // Frame events to the drive
	output gcfs_reg_t reg_req,         // Register accesses to the drive
	input wire logic [15:0] reg_rdata  // Register read data
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	// Released lines carry noise, so a stale value never passes for a request
	task automatic idle();
		frame <= gcfs_frame_t'(20'($urandom) & 20'h7ffff);
		reg_req <= gcfs_reg_t'({2'b00, $urandom});
	endtask : idle

	initial idle();

	// One frame event, done held for exactly one edge
	task automatic send(input logic [7:0] st, input logic crc, input logic exc, input logic [7:0] code,
		input logic nvb);
		@(posedge clk);
		frame <= '{done: 1'b1, crc_error: crc, station: st, exception: exc, exc_code: code, exc_nvbusy: nvb};
		@(posedge clk);
		idle();
	endtask : send

	// Always addressed to this one drive, never a group send
	task automatic write_reg(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		idle();
	endtask : write_reg

	// Read data taken at the edge that ends the access
	task automatic read_reg(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk);
		d = reg_rdata;
		idle();
	endtask : read_reg
endmodule : gcfs_master_model

// ==== sim/gcfs_supervisor_assertions.sv ====
// Port-level checker for the group-send and fault supervisor
module gcfs_supervisor_assertions
	import gcfs_pkg::*;
(
	input wire logic clk,               // Clock
	input wire logic nrst,              // Async reset, active low
	input wire logic [7:0] own_station, // Own address
	input wire gcfs_frame_t frame,      // Frame events
	input wire logic [15:0] timeout_ms, // Timeout setting
	input wire logic [3:0] err_limit,   // Error threshold
	input wire logic forward_run_input, // Run pin
	input wire logic reverse_run_input, // Run pin
	input wire logic alarm_reset_cmd,   // Serial clear
	input wire logic reply_enable,      // Reply allowed
	input wire logic execute,           // Execute pulse
	input wire logic alarm_out,         // High when no alarm
	input wire logic warning_output,    // Warning pin
	input wire logic motor_stop,        // Motor stop
	input wire logic [7:0] alarm_code,  // Active alarm
	input wire logic [7:0] warning_code, // Active warning
	input wire logic fault_lamp,        // Alarm lamp
	input wire logic power_fault_lamp   // Combined lamp
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// ------------------------------------------------------------
	// Consecutive bad-frame count, mirrors the alarm threshold
	// ------------------------------------------------------------
	wire frame_bad = frame.done && frame.crc_error;
	wire frame_good = frame.done && !frame.crc_error;
	logic [3:0] bad_run;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bad_run <= 4'h0;
		end else if (frame_good || (frame_bad && bad_run + 4'h1 >= err_limit)) begin
			bad_run <= 4'h0;
		end else if (frame_bad) begin
			bad_run <= bad_run + 4'h1;
		end
	end

	sequence s_good_own;
		frame_good && frame.station == own_station;
	endsequence
	sequence s_bad;
		frame_bad && alarm_code == gcfs_alm_none && timeout_ms == 16'h0000;
	endsequence

	property p_own_reply;
		s_good_own |=> execute && reply_enable;
	endproperty
	a_own_reply: assert property (p_own_reply) else $error("own frame not executed with reply");
	property p_idle_quiet;
		!frame.done |=> !execute;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("execute without frame");
	property p_bad_warn;
		frame_bad |=> !execute && !reply_enable && warning_output && warning_code == gcfs_wrn_comm;
	endproperty
	a_bad_warn: assert property (p_bad_warn) else $error("bad frame handling wrong");
	property p_good_warn_off;
		frame_good |=> !warning_output && warning_code == 8'h00;
	endproperty
	a_good_warn_off: assert property (p_good_warn_off) else $error("warning kept after good frame");
	property p_err_alarm;
		s_bad ##0 (bad_run + 4'h1 == err_limit) |=> alarm_code == gcfs_alm_comm;
	endproperty
	a_err_alarm: assert property (p_err_alarm) else $error("threshold alarm missing");
	property p_under_limit;
		s_bad ##0 (bad_run + 4'h1 < err_limit) |=> alarm_code == gcfs_alm_none;
	endproperty
	a_under_limit: assert property (p_under_limit) else $error("alarm below threshold");
	property p_alarm_outputs;
		alarm_out == (alarm_code == gcfs_alm_none) && motor_stop == !alarm_out;
	endproperty
	a_alarm_outputs: assert property (p_alarm_outputs) else $error("alarm outputs disagree");
	property p_lamp;
		power_fault_lamp == (alarm_out || fault_lamp);
	endproperty
	a_lamp: assert property (p_lamp) else $error("combined lamp wrong");
	property p_run_blocks_clear;
		(forward_run_input || reverse_run_input) [*6] ##0 (alarm_code != gcfs_alm_none && !alarm_reset_cmd)
			|=> $stable(alarm_code);
	endproperty
	a_run_blocks_clear: assert property (p_run_blocks_clear) else $error("clear taken while running");
	property p_cmd_clears;
		alarm_reset_cmd && !frame_bad && timeout_ms == 16'h0000 |=> alarm_code == gcfs_alm_none;
	endproperty
	a_cmd_clears: assert property (p_cmd_clears) else $error("serial clear ignored");
endmodule : gcfs_supervisor_assertions

// ==== sim/gcfs_supervisor_tb_top.sv ====
// Self-checking bench for the group-send and fault supervisor
module gcfs_supervisor_tb_top
	import gcfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Signals, design and master
	// ------------------------------------------------------------
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic forward_run_input = 1'b0;
	logic reverse_run_input = 1'b0;
	logic alarm_reset_input = 1'b0;
	logic alarm_reset_cmd = 1'b0;
	logic hist_clear_cmd = 1'b0;
	logic [7:0] own_station;
	logic [15:0] timeout_ms = 16'h0000;
	logic [3:0] err_limit = 4'h3;
	logic [3:0] hist_index = 4'h0;
	logic [2:0] rec_index = 3'h0;
	gcfs_frame_t frame;
	gcfs_reg_t reg_req;
	logic [15:0] reg_rdata;
	logic reply_enable, execute, alarm_out, warning_output, motor_stop, fault_lamp, power_fault_lamp;
	logic [7:0] hist_code, rec_code, alarm_code, warning_code;
	logic exp_q[$];
	int n_errors = 0;
	int checks_done = 0;
	logic [7:0] exc_tab[5] = '{gcfs_exc_func, gcfs_exc_addr, gcfs_exc_value, gcfs_exc_fail, gcfs_exc_fail};
	logic [7:0] rec_tab[5] = '{gcfs_err_nvbusy, gcfs_err_disable, gcfs_err_range, gcfs_err_undef, gcfs_err_undef};

	// Short hold and millisecond so clears and timeouts fit the run
	gcfs_supervisor #(.clear_hold(20), .ms_div(4)) i_gcfs_supervisor (.clk, .nrst, .own_station, .frame,
		.reg_req, .reg_rdata, .reply_enable, .execute, .timeout_ms, .err_limit, .forward_run_input,
		.reverse_run_input, .alarm_reset_input, .alarm_reset_cmd, .hist_clear_cmd, .hist_index, .hist_code,
		.rec_index, .rec_code, .alarm_out, .warning_output, .motor_stop, .alarm_code, .warning_code,
		.fault_lamp, .power_fault_lamp);
	gcfs_master_model i_gcfs_master_model (.clk, .frame, .reg_req, .reg_rdata);

	always #20 clk = ~clk;

	// ------------------------------------------------------------
	// Checking and driving tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// Each execute pulse takes the oldest expected reply flag; none left is a fault
	always @(posedge clk) begin
		if (execute === 1'b1) begin
			check("reply_enable", 16'(reply_enable), exp_q.size() ? 16'(exp_q.pop_front()) : 16'h00ff);
		end
	end

	task automatic fr(input logic [7:0] st, input logic crc, input logic exc, input logic [7:0] code,
		input logic nvb, input logic ex);
		if (ex) exp_q.push_back(st == own_station && !crc);
		i_gcfs_master_model.send(st, crc, exc, code, nvb);
		cyc(2);
		check("pending execute", 16'(exp_q.size()), 16'h0000);
	endtask : fr

	task automatic peek(input logic rec, input int i, input logic [7:0] exp);
		@(posedge clk);
		rec_index <= 3'(i);
		hist_index <= 4'(i);
		@(posedge clk);
		check(rec ? "rec_code" : "hist_code", 16'(rec ? rec_code : hist_code), 16'(exp));
	endtask : peek

	// Runs must already be off for this to count
	task automatic pin_clear();
		@(posedge clk);
		alarm_reset_input <= 1'b1; // Held beyond the minimum time
		cyc(30);
		alarm_reset_input <= 1'b0;
		cyc(10);
	endtask : pin_clear

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [15:0] d;
		logic [7:0] par;
		void'($urandom(72));
		own_station = 8'(1 + $urandom % 15);
		par = own_station + 8'h10;
		cyc(2);
		nrst <= 1'b1;
		cyc(1);
		check("alarm_out", 16'({alarm_out, power_fault_lamp}), 16'h0003);
		i_gcfs_master_model.read_reg(gcfs_group_addr_offset, d);
		check("group", d, gcfs_group_reset);
		fr(par, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
		i_gcfs_master_model.write_reg(gcfs_group_addr_offset, {8'h00, par});
		i_gcfs_master_model.read_reg(gcfs_group_addr_offset, d);
		check("group", d, {8'h00, par});
		i_gcfs_master_model.read_reg(16'h0032, d);
		check("unmapped", d, 16'h0000);
		fr(par, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1);
		fr(own_station, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1);
		i_gcfs_master_model.write_reg(gcfs_group_addr_offset, 16'h0040);
		fr(8'h40, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
		i_gcfs_master_model.write_reg(gcfs_group_addr_offset, gcfs_group_none);
		fr(par, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
		// Every exception flavour, then the record newest first
		for (int i = 0; i < 5; i++) begin
			fr(own_station, 1'b0, 1'b1, exc_tab[i], i == 4, 1'b1);
		end
		fr(8'h7f, 1'b0, 1'b1, gcfs_exc_value, 1'b0, 1'b0);
		for (int i = 0; i < 5; i++) begin
			peek(1'b1, i, rec_tab[i]);
		end
		// A good frame between bad ones restarts the run
		fr(own_station, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
		check("warning", 16'({warning_output, warning_code}), 16'h0120);
		fr(own_station, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1);
		check("warning", 16'({warning_output, warning_code}), 16'h0000);
		repeat (2) fr(own_station, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
		check("alarm", 16'(alarm_code), 16'h0000);
		fr(own_station, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
		check("alarm", 16'({alarm_out, motor_stop, alarm_code}), {8'h01, gcfs_alm_comm});
		check("lamps", 16'({fault_lamp, power_fault_lamp}), 16'h0003);
		peek(1'b1, 0, gcfs_err_xmit);
		for (int k = 1; k < 3; k++) begin
			@(posedge clk);
			{reverse_run_input, forward_run_input} <= 2'(k);
			cyc(4);
			pin_clear();
			check("alarm", 16'(alarm_code), 16'(gcfs_alm_comm));
		end
		@(posedge clk);
		{reverse_run_input, forward_run_input} <= 2'b00;
		cyc(4);
		pin_clear();
		check("alarm", 16'(alarm_code), 16'h0000);
		check("lamps", 16'({fault_lamp, power_fault_lamp}), 16'h0001);
		@(posedge clk);
		timeout_ms <= 16'h0002;
		for (int n = 0; n < 80 && alarm_code === gcfs_alm_none; n++) @(posedge clk);
		if (alarm_code === gcfs_alm_none) begin
			n_errors++;
			end_sim();
		end
		check("alarm", 16'(alarm_code), 16'(gcfs_alm_timeout));
		peek(1'b1, 0, gcfs_err_timeout);
		@(posedge clk);
		timeout_ms <= 16'h0000;
		alarm_reset_cmd <= 1'b1;
		@(posedge clk);
		alarm_reset_cmd <= 1'b0;
		cyc(2);
		check("alarm", 16'(alarm_code), 16'h0000);
		peek(1'b0, 0, gcfs_alm_timeout);
		peek(1'b0, 1, gcfs_alm_comm);
		@(posedge clk);
		hist_clear_cmd <= 1'b1;
		@(posedge clk);
		hist_clear_cmd <= 1'b0;
		peek(1'b0, 0, 8'h00);
		end_sim();
	end
endmodule : gcfs_supervisor_tb_top

bind gcfs_supervisor gcfs_supervisor_assertions i_gcfs_supervisor_assertions (.clk, .nrst, .own_station, .frame,
	.timeout_ms, .err_limit, .forward_run_input, .reverse_run_input, .alarm_reset_cmd, .reply_enable, .execute,
	.alarm_out, .warning_output, .motor_stop, .alarm_code, .warning_code, .fault_lamp, .power_fault_lamp);

// ==== src/gcfs_blinker.sv ====
// Fault lamp blink-count generator
module gcfs_blinker
	import gcfs_pkg::*;
#(
	parameter int on_cycles = gcfs_blink_on_ms * gcfs_ms_cycles,
	parameter int gap_cycles = gcfs_blink_gap_ms * gcfs_ms_cycles
) (
	input wire logic clk,         // 25 MHz clock
	input wire logic nrst,        // Async reset, active low
	input wire logic [7:0] count, // Blinks per burst, zero is off
	output logic lamp             // Lamp drive
);
	// ------------------------------------------------------------
	// Burst sequencer
	// ------------------------------------------------------------
	logic [31:0] timer;
	logic [7:0] done_blinks;
	logic phase_on;
	logic in_gap;
	wire logic timer_end = (timer == 32'h0);

	// One on and one off period per blink, the last blink's off period being the long gap
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			timer <= 32'h0;
			done_blinks <= 8'h0;
			phase_on <= 1'b0;
			in_gap <= 1'b1;
			lamp <= 1'b0;
		end else if (count == 8'h0) begin
			timer <= 32'h0;
			done_blinks <= 8'h0;
			phase_on <= 1'b0;
			in_gap <= 1'b1;
			lamp <= 1'b0;
		end else if (!timer_end) begin
			timer <= timer - 32'h1;
		end else if (in_gap || !phase_on) begin
			if (in_gap) begin
				done_blinks <= 8'h0;
			end
			in_gap <= 1'b0;
			phase_on <= 1'b1;
			lamp <= 1'b1;
			timer <= 32'(on_cycles - 1);
		end else begin
			phase_on <= 1'b0;
			lamp <= 1'b0;
			done_blinks <= done_blinks + 8'h1;
			if (done_blinks + 8'h1 >= count) begin
				in_gap <= 1'b1;
				timer <= 32'(gap_cycles - 1);
			end else begin
				timer <= 32'(on_cycles - 1);
			end
		end
	end

endmodule : gcfs_blinker

// ==== src/gcfs_supervisor.sv ====
// Group-send filter and communication fault supervisor
module gcfs_supervisor
	import gcfs_pkg::*;
#(
	parameter int clear_hold = gcfs_clear_hold_cycles,
	parameter int ms_div = gcfs_ms_cycles,
	parameter int hist_depth = gcfs_hist_depth,
	parameter int rec_depth = gcfs_rec_depth
) (
	input wire logic clk,                    // 25 MHz clock
	input wire logic nrst,                   // Async reset, active low
	input wire logic [7:0] own_station,      // This drive's station address
	input wire gcfs_frame_t frame,           // Frame event from protocol engine
	input wire gcfs_reg_t reg_req,           // Register access
	output logic [15:0] reg_rdata,           // Register read data
	output logic reply_enable,               // Reply may be sent for last frame
	output logic execute,                    // Frame addressed to us, pulse
	input wire logic [15:0] timeout_ms,      // Timeout setting, 0 off
	input wire logic [3:0] err_limit,        // Consecutive error threshold
	input wire logic forward_run_input,      // Pin, async
	input wire logic reverse_run_input,      // Pin, async
	input wire logic alarm_reset_input,      // Pin, async
	input wire logic alarm_reset_cmd,        // Serial reset command pulse
	input wire logic hist_clear_cmd,         // Serial history clear pulse
	input wire logic [3:0] hist_index,       // History read index
	output logic [7:0] hist_code,            // History entry, 0 if empty
	input wire logic [2:0] rec_index,        // Error record read index
	output logic [7:0] rec_code,             // Error record entry
	output logic alarm_out,                  // High while no alarm
	output logic warning_output,             // High while warning
	output logic motor_stop,                 // High while alarm stops motor
	output logic [7:0] alarm_code,           // Active alarm code
	output logic [7:0] warning_code,         // Active warning code
	output logic fault_lamp,                 // Blinking alarm lamp
	output logic power_fault_lamp            // Lit when fine, blinks on alarm
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_meta <= 3'h0;
			pin_sync <= 3'h0;
		end else begin
			pin_meta <= {alarm_reset_input, reverse_run_input, forward_run_input};
			pin_sync <= pin_meta;
		end
	end
	wire logic fwd_s = pin_sync[0];
	wire logic rev_s = pin_sync[1];
	wire logic rst_s = pin_sync[2];

	// ------------------------------------------------------------
	// Group address register
	// ------------------------------------------------------------
	// Plain flops only: no path to nonvolatile storage exists
	logic [15:0] group_membership_address;
	wire logic grp_hit = reg_req.addr == gcfs_group_addr_offset;
	wire logic grp_valid = group_membership_address[15:8] == 8'h0 &&
		group_membership_address[7:0] >= gcfs_group_min &&
		group_membership_address[7:0] <= gcfs_group_max;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			group_membership_address <= gcfs_group_reset;
		end else if (reg_req.wr && grp_hit) begin
			group_membership_address <= reg_req.wdata;
		end
	end
	assign reg_rdata = grp_hit ? group_membership_address : 16'h0000;

	// ------------------------------------------------------------
	// Group-send address filter
	// ------------------------------------------------------------
	wire logic own_hit = frame.station == own_station;
	wire logic group_hit = grp_valid && frame.station == group_membership_address[7:0] &&
		!own_hit;
	wire logic good_frame = frame.done && !frame.crc_error;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			execute <= 1'b0;
			reply_enable <= 1'b0;
		end else begin
			execute <= good_frame && (own_hit || group_hit);
			if (frame.done) begin
				reply_enable <= good_frame && own_hit;
			end
		end
	end

	// ------------------------------------------------------------
	// Timeout monitor on a millisecond enable
	// ------------------------------------------------------------
	logic [31:0] ms_cnt;
	logic [15:0] idle_ms;
	logic timeout_hit;
	wire logic ms_tick = ms_cnt == 32'(ms_div - 1);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ms_cnt <= 32'h0;
			idle_ms <= 16'h0;
			timeout_hit <= 1'b0;
		end else begin
			ms_cnt <= ms_tick ? 32'h0 : ms_cnt + 32'h1;
			timeout_hit <= 1'b0;
			if (good_frame || timeout_ms == 16'h0) begin
				idle_ms <= 16'h0;
			end else if (ms_tick && idle_ms != 16'hffff) begin
				idle_ms <= idle_ms + 16'h1;
				timeout_hit <= idle_ms + 16'h1 == timeout_ms;
			end
		end
	end

	// ------------------------------------------------------------
	// Consecutive error counter and warning
	// ------------------------------------------------------------
	logic [3:0] err_run;
	wire logic bad_frame = frame.done && frame.crc_error;
	wire logic err_alarm_hit = bad_frame && err_run + 4'h1 >= err_limit;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			err_run <= 4'h0;
			warning_output <= 1'b0;
		end else if (bad_frame) begin
			err_run <= err_alarm_hit ? 4'h0 : err_run + 4'h1;
			warning_output <= 1'b1;
		end else if (good_frame) begin
			err_run <= 4'h0;
			warning_output <= 1'b0;
		end
	end
	assign warning_code = warning_output ? gcfs_wrn_comm : 8'h00;

	// ------------------------------------------------------------
	// Clear input qualifier
	// ------------------------------------------------------------
	logic [31:0] hold_cnt;
	logic hold_ok;
	logic pin_clear;
	wire logic runs_off = !fwd_s && !rev_s;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hold_cnt <= 32'h0;
			hold_ok <= 1'b0;
			pin_clear <= 1'b0;
		end else begin
			pin_clear <= 1'b0;
			if (!runs_off) begin
				hold_cnt <= 32'h0;
				hold_ok <= 1'b0;
			end else if (rst_s) begin
				if (hold_cnt < 32'(clear_hold)) begin
					hold_cnt <= hold_cnt + 32'h1;
				end else begin
					hold_ok <= 1'b1;
				end
			end else begin
				pin_clear <= hold_ok; // Acts on release
				hold_cnt <= 32'h0;
				hold_ok <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Alarm state and history
	// ------------------------------------------------------------
	// New alarm wins over a clear arriving in the same cycle
	wire logic new_alarm = (err_alarm_hit || timeout_hit) && alarm_code == gcfs_alm_none;
	wire logic [7:0] new_code = err_alarm_hit ? gcfs_alm_comm : gcfs_alm_timeout;
	wire logic do_clear = pin_clear || alarm_reset_cmd;
	logic [7:0] hist [hist_depth];
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			alarm_code <= gcfs_alm_none;
		end else if (new_alarm) begin
			alarm_code <= new_code;
		end else if (do_clear) begin
			alarm_code <= gcfs_alm_none;
		end
	end

	// History shifts newest into slot zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < hist_depth; i++) hist[i] <= 8'h00;
		end else if (new_alarm) begin
			hist[0] <= new_code;
			for (int i = 1; i < hist_depth; i++) hist[i] <= hist[i - 1];
		end else if (hist_clear_cmd) begin
			for (int i = 0; i < hist_depth; i++) hist[i] <= 8'h00;
		end
	end
	assign hist_code = int'(hist_index) < hist_depth ? hist[hist_index] : 8'h00;

	// ------------------------------------------------------------
	// Communication error record
	// ------------------------------------------------------------
	function automatic logic [7:0] exc_to_rec(input logic [7:0] exc, input logic nvbusy);
		if (exc == gcfs_exc_func || exc == gcfs_exc_addr) begin
			return gcfs_err_undef;
		end else if (exc == gcfs_exc_value) begin
			return gcfs_err_range;
		end else if (exc == gcfs_exc_fail) begin
			return nvbusy ? gcfs_err_nvbusy : gcfs_err_disable;
		end
		return 8'h00;
	endfunction : exc_to_rec

	logic [7:0] rec [rec_depth];
	wire logic [7:0] exc_rec = exc_to_rec(frame.exc_code, frame.exc_nvbusy);
	wire logic rec_exc = good_frame && own_hit && frame.exception && exc_rec != 8'h00; // Answered only
	wire logic rec_log = bad_frame || timeout_hit || rec_exc;
	wire logic [7:0] rec_val = bad_frame ? gcfs_err_xmit :
		timeout_hit ? gcfs_err_timeout : exc_rec;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < rec_depth; i++) rec[i] <= 8'h00;
		end else if (rec_log) begin
			rec[0] <= rec_val;
			for (int i = 1; i < rec_depth; i++) rec[i] <= rec[i - 1];
		end
	end
	assign rec_code = rec[rec_index];

	// ------------------------------------------------------------
	// Outputs and lamps
	// ------------------------------------------------------------
	wire logic alarm_active = alarm_code != gcfs_alm_none;
	assign alarm_out = !alarm_active;
	assign motor_stop = alarm_active;
	logic blink;
	gcfs_blinker u_blink (
		.clk(clk),
		.nrst(nrst),
		.count(alarm_code),
		.lamp(blink)
	);
	assign fault_lamp = blink;
	assign power_fault_lamp = alarm_active ? blink : 1'b1;

endmodule : gcfs_supervisor
